// [gio_pkg.sv]
package gio_pkg;

  // Register byte addresses; 0x103 is not word aligned, so printed offsets are indices.
  localparam logic [11:0] SERIAL_IO_IDX = 12'h0100;
  localparam logic [11:0] OUT_CLOCK_IDX = 12'h0103;
  localparam logic [11:0] IN_BAND_IDX = 12'h0104;
  localparam logic [13:0] SERIAL_IO_ADDR = {SERIAL_IO_IDX, 2'b00};
  localparam logic [13:0] OUT_CLOCK_ADDR = {OUT_CLOCK_IDX, 2'b00};
  localparam logic [13:0] IN_BAND_ADDR = {IN_BAND_IDX, 2'b00};

  localparam int SIO_PRE_SUPPRESS_BIT = 2;
  localparam int SIO_AUTO_EDGE_BIT = 1;
  localparam int SIO_MANUAL_EDGE_BIT = 0;
  localparam logic [4:0] SIO_RSVD_RESET = 5'h08;
  localparam logic [2:0] SIO_CTRL_RESET = 3'h2;

  localparam int OCK_READY_BIT = 7;
  localparam logic [2:0] OCK_SRC_RESET = 3'h0;
  localparam logic [2:0] OCK_SRC_MAX = 3'h5;
  localparam logic OCK_EN_RESET = 1'b1;
  localparam logic OCK_FREQ_RESET = 1'b0;

  localparam logic IBA_MATCH_RESET = 1'b0;
  localparam logic [1:0] IBA_QUEUE_RESET = 2'h1;
  localparam logic [2:0] IBA_PORT_RESET = 3'h6;
  localparam logic [2:0] IBA_PORT_RSVD = 3'h7;
  localparam logic [15:0] IBA_TAG_RESET = 16'h40fe;

  // Serial clock at or above 25 MHz counts as fast; measured in core clocks at 50 MHz.
  localparam int CLK_HZ = 50_000_000;
  localparam int EDGE_THRESH_HZ = 25_000_000;
  localparam int FAST_PERIOD_CYC = CLK_HZ / EDGE_THRESH_HZ;
  localparam logic [7:0] FAST_PERIOD_MAX = 8'(FAST_PERIOD_CYC);

  typedef struct packed {
    logic pre_suppress;
    logic auto_edge;
    logic manual_edge;
  } gio_sio_s;

  typedef struct packed {
    logic [2:0] src;
    logic enable;
    logic freq_125;
  } gio_ock_s;

  typedef struct packed {
    logic enable;
    logic addr_match;
    logic [1:0] queue;
    logic [2:0] port;
    logic [15:0] tag;
  } gio_iba_s;

endpackage

// [gio_sync3.sv]
module gio_sync3 (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic d_in,
  output logic q_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // The output changes only once the last two stages agree.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_out <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      q_out <= s3_reg;
    end
  end
endmodule

// [gio_edge_sel.sv]
module gio_edge_sel (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic serial_clk_in,
  input wire logic auto_edge_in,
  input wire logic manual_edge_in,
  output logic launch_rising_out
);
  logic sclk_s1_reg;
  logic sclk_s2_reg;
  logic sclk_prev_reg;
  logic [7:0] period_reg;
  logic fast_reg;

  // A fast serial clock toggles every core cycle, so its stages never agree; the
  // period is measured on raw rising edges after the metastability stages instead.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_s1_reg <= serial_clk_in;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_prev_reg <= sclk_s2_reg;
    end
  end

  // Serial clock period in core clocks; the counter starts saturated so the first edge reads slow.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      period_reg <= 8'hff;
      fast_reg <= 1'b0;
    end else begin
      if (sclk_s2_reg && !sclk_prev_reg) begin
        fast_reg <= (period_reg <= gio_pkg::FAST_PERIOD_MAX);
        period_reg <= 8'h01;
      end else if (period_reg != 8'hff) begin
        period_reg <= period_reg + 8'h01;
      end else begin
        fast_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      launch_rising_out <= 1'b0;
    end else begin
      launch_rising_out <= auto_edge_in ? fast_reg : manual_edge_in;
    end
  end
endmodule

// [gio_ctrl_regs.sv]
// How it works
// - Preamble required unless suppression bit set.
// - Suppression affects management serial port only.
// - Auto edge: rising at fast clock, else falling.
// - Auto edge resets set, overrides manual bit.
// - Manual bit: 0 falling, 1 rising.
// - Bit 7 reports selected recovered clock ready.
// - Sync clock source, pin enable, frequency select.
// - In-band enable taken from strap at reset; code resets it to 0, then follows the synchronised strap until a bit 31 write.
// - Address match enable drops mismatched frames.
// - Writing bit 29 resets state machine, self-clears.
// - Response priority queue field, reset 01.
// - In-band port field, code 111 reserved.
// - Tag type field, reset 0x40FE.
//
// The implementer's own choice: the APB interface to the registers.
module gio_ctrl_regs (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_band_strap_in,
  input wire logic serial_clk_in,
  input wire logic [4:0] recovered_clock_ready_in,
  input wire logic crystal_ready_in,
  input wire logic mgmt_frame_valid_in,
  input wire logic mgmt_frame_preamble_in,
  input wire logic host_frame_valid_in,
  input wire logic in_band_frame_valid_in,
  input wire logic [47:0] in_band_dest_addr_in,
  input wire logic [47:0] switch_mac_addr_in,
  output logic mgmt_cmd_accept_out,
  output logic host_cmd_accept_out,
  output logic spi_serial_out_rising_out,
  output logic [2:0] sync_clock_out_src_out,
  output logic sync_clock_out_en_out,
  output logic sync_clock_out_125_out,
  output gio_pkg::gio_iba_s in_band_access_cfg_out,
  output logic in_band_access_accept_out,
  output logic in_band_access_reset_out
);
  gio_pkg::gio_sio_s sio_reg;
  gio_pkg::gio_ock_s ock_reg;
  gio_pkg::gio_iba_s iba_reg;
  logic iba_reset_reg;
  logic strap_sync;
  logic strap_taken_reg;
  logic rec_ready;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [13:0] word_addr;

  // True when the address names one of the three registers.
  function automatic logic is_mapped(input logic [13:0] a);
    is_mapped = (a == gio_pkg::SERIAL_IO_ADDR) || (a == gio_pkg::OUT_CLOCK_ADDR) ||
                (a == gio_pkg::IN_BAND_ADDR);
  endfunction

  assign word_addr = paddr[13:0];
  assign addr_ok = is_mapped(word_addr) && (paddr[31:14] == 18'h0_0000) && (paddr[1:0] == 2'b00);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok;
  // Read data are loaded in the setup cycle so that they stand at the access edge.
  assign rd_en = psel && !penable && !pwrite && addr_ok;

  gio_sync3 u_strap (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(in_band_strap_in),
    .q_out(strap_sync)
  );

  gio_edge_sel u_edge (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .serial_clk_in(serial_clk_in),
    .auto_edge_in(sio_reg.auto_edge),
    .manual_edge_in(sio_reg.manual_edge),
    .launch_rising_out(spi_serial_out_rising_out)
  );

  // Serial control: only the three low bits are stored; bits 7:3 read fixed.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sio_reg <= gio_pkg::SIO_CTRL_RESET;
    end else if (wr_en && word_addr == gio_pkg::SERIAL_IO_ADDR && pstrb[0]) begin
      sio_reg.pre_suppress <= pwdata[gio_pkg::SIO_PRE_SUPPRESS_BIT];
      sio_reg.auto_edge <= pwdata[gio_pkg::SIO_AUTO_EDGE_BIT];
      sio_reg.manual_edge <= pwdata[gio_pkg::SIO_MANUAL_EDGE_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ock_reg.src <= gio_pkg::OCK_SRC_RESET;
      ock_reg.enable <= gio_pkg::OCK_EN_RESET;
      ock_reg.freq_125 <= gio_pkg::OCK_FREQ_RESET;
    end else if (wr_en && word_addr == gio_pkg::OUT_CLOCK_ADDR && pstrb[0]) begin
      ock_reg.src <= pwdata[4:2];
      ock_reg.enable <= pwdata[1];
      ock_reg.freq_125 <= pwdata[0];
    end
  end

  // In-band enable follows the strap until software writes it once after reset.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      iba_reg.enable <= 1'b0;
      strap_taken_reg <= 1'b0;
      iba_reg.addr_match <= gio_pkg::IBA_MATCH_RESET;
      iba_reg.queue <= gio_pkg::IBA_QUEUE_RESET;
      iba_reg.port <= gio_pkg::IBA_PORT_RESET;
      iba_reg.tag <= gio_pkg::IBA_TAG_RESET;
    end else begin
      if (wr_en && word_addr == gio_pkg::IN_BAND_ADDR) begin
        if (pstrb[3]) begin
          iba_reg.enable <= pwdata[31];
          iba_reg.addr_match <= pwdata[30];
          strap_taken_reg <= 1'b1;
        end else if (!strap_taken_reg) begin
          iba_reg.enable <= strap_sync;
        end
        if (pstrb[2]) begin
          iba_reg.queue <= pwdata[23:22];
          iba_reg.port <= pwdata[18:16];
        end
        if (pstrb[1]) begin
          iba_reg.tag[15:8] <= pwdata[15:8];
        end
        if (pstrb[0]) begin
          iba_reg.tag[7:0] <= pwdata[7:0];
        end
      end else if (!strap_taken_reg) begin
        iba_reg.enable <= strap_sync;
      end
    end
  end

  // Reset request is a one-cycle pulse; the stored bit clears itself.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      iba_reset_reg <= 1'b0;
    end else begin
      iba_reset_reg <= wr_en && word_addr == gio_pkg::IN_BAND_ADDR && pstrb[3] && pwdata[29];
    end
  end

  assign in_band_access_reset_out = iba_reset_reg;

  always_comb begin
    if (ock_reg.src == gio_pkg::OCK_SRC_RESET) begin
      rec_ready = crystal_ready_in;
    end else if (ock_reg.src <= gio_pkg::OCK_SRC_MAX) begin
      rec_ready = recovered_clock_ready_in[ock_reg.src - 3'h1];
    end else begin
      rec_ready = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      if (word_addr == gio_pkg::SERIAL_IO_ADDR) begin
        prdata <= {24'h00_0000, gio_pkg::SIO_RSVD_RESET, sio_reg};
      end else if (word_addr == gio_pkg::OUT_CLOCK_ADDR) begin
        prdata <= {24'h00_0000, rec_ready, 2'b00, ock_reg};
      end else begin
        prdata <= {iba_reg.enable, iba_reg.addr_match, 1'b0, 5'h00, iba_reg.queue, 3'h0, iba_reg.port,
                   iba_reg.tag};
      end
    end
  end

  // Management serial commands need a preamble unless suppression is set.
  always_comb begin
    mgmt_cmd_accept_out = mgmt_frame_valid_in && (mgmt_frame_preamble_in || sio_reg.pre_suppress);
    host_cmd_accept_out = host_frame_valid_in;
  end

  always_comb begin
    in_band_access_accept_out = in_band_frame_valid_in && iba_reg.enable && !iba_reset_reg &&
                                (iba_reg.port != gio_pkg::IBA_PORT_RSVD) &&
                                (!iba_reg.addr_match || in_band_dest_addr_in == switch_mac_addr_in);
  end

  assign sync_clock_out_src_out = ock_reg.src;
  assign sync_clock_out_en_out = ock_reg.enable;
  assign sync_clock_out_125_out = ock_reg.freq_125;
  assign in_band_access_cfg_out = iba_reg;
endmodule

// [gio_regs_chk_sva.sv]
module gio_regs_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic mgmt_frame_valid_in,
  input wire logic mgmt_frame_preamble_in,
  input wire logic in_band_frame_valid_in,
  input wire logic [47:0] in_band_dest_addr_in,
  input wire logic [47:0] switch_mac_addr_in,
  input wire logic mgmt_cmd_accept_out,
  input wire gio_pkg::gio_iba_s in_band_access_cfg_out,
  input wire logic in_band_access_accept_out,
  input wire logic in_band_access_reset_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  wire acc = psel && penable;
  unmapped_err_a: assert property (acc && paddr == 32'h0000_0408 |-> pslverr)
    else $error("unmapped access not flagged");
  pre_accept_a: assert property (mgmt_frame_valid_in && mgmt_frame_preamble_in |-> mgmt_cmd_accept_out)
    else $error("command with preamble refused");
  idle_accept_a: assert property (!mgmt_frame_valid_in |-> !mgmt_cmd_accept_out)
    else $error("command accepted without frame");
  pulse_once_a: assert property (in_band_access_reset_out |=> !in_band_access_reset_out)
    else $error("state reset longer than one cycle");
  pulse_cause_a: assert property (in_band_access_reset_out |->
    $past(acc && pwrite && pwdata[29] && paddr == 32'(gio_pkg::IN_BAND_ADDR))) else $error("state reset uncaused");
  accept_gate_a: assert property (in_band_access_accept_out |-> in_band_frame_valid_in &&
    in_band_access_cfg_out.enable && in_band_access_cfg_out.port != 3'h7) else $error("frame accepted wrongly");
  addr_match_a: assert property (in_band_access_accept_out && in_band_access_cfg_out.addr_match |->
    in_band_dest_addr_in == switch_mac_addr_in) else $error("foreign address accepted");
  tag_hold_a: assert property (!(acc && pwrite) |=> $stable(in_band_access_cfg_out.tag))
    else $error("tag changed without write");
  cover property (in_band_access_reset_out);
  cover property (in_band_access_accept_out);
  cover property (pslverr);
endmodule

bind gio_ctrl_regs gio_regs_chk chk_i (.clk_in, .rst_in, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
  .mgmt_frame_valid_in, .mgmt_frame_preamble_in, .in_band_frame_valid_in, .in_band_dest_addr_in,
  .switch_mac_addr_in, .mgmt_cmd_accept_out, .in_band_access_cfg_out, .in_band_access_accept_out,
  .in_band_access_reset_out);

// [gio_host.sv]
module gio_host (
  input wire logic clk_in,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
  end
  // Read data and the error flag are taken at the edge where pready is seen high.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
    @(posedge clk_in);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'h1;
    do @(posedge clk_in); while (pready !== 1'h1);
    e = pslverr;
    r = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule

// [test_global_io_control_regs.sv]
module test_global_io_control_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, rst_in = 1, strap = 1, sck = 0, xtal = 1, mv = 0, mp = 0, hv = 0, iv = 0;
  logic psel, penable, pwrite, pready, pslverr, e, ma, ha, ri, cen, cf, ia;
  logic [2:0] src;
  logic [3:0] pstrb;
  logic [4:0] rec = 0;
  logic [15:0] rnd = 16'h0006;
  logic [47:0] dst = 0, mac = 48'h0000_1234_5678;
  logic [31:0] paddr, pwdata, prdata, r, sio = 32'h0000_0042, ock = 32'h0000_0002, inb = 32'h8046_40fe;
  logic [31:0] ad [3];
  logic [31:0] tab [5] = '{32'he04e_1234, 32'hc04e_1234, 32'h8007_0000, 32'h8000_0000, 32'h4000_0000};
  gio_pkg::gio_iba_s cfg;
  int err_count = 0, checked = 0, cyc = 0;
  always #10 clk_in = ~clk_in;
  gio_host host (.clk_in, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb);
  gio_ctrl_regs dut (.clk_in, .rst_in, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .in_band_strap_in(strap), .serial_clk_in(sck), .recovered_clock_ready_in(rec),
    .crystal_ready_in(xtal), .mgmt_frame_valid_in(mv), .mgmt_frame_preamble_in(mp), .host_frame_valid_in(hv),
    .in_band_frame_valid_in(iv), .in_band_dest_addr_in(dst), .switch_mac_addr_in(mac), .mgmt_cmd_accept_out(ma),
    .host_cmd_accept_out(ha), .spi_serial_out_rising_out(ri), .sync_clock_out_src_out(src),
    .sync_clock_out_en_out(cen), .sync_clock_out_125_out(cf), .in_band_access_cfg_out(cfg),
    .in_band_access_accept_out(ia), .in_band_access_reset_out());
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] rd_exp(int i);
    int s = ock[4:2];
    logic rdy = s == 0 ? xtal : s < 6 ? rec[s - 1] : 1'h0;
    return i == 0 ? sio : i == 1 ? {ock[31:8], rdy, ock[6:0]} : inb;
  endfunction
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    checked++;
    if (s !== x) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic rdall();
    for (int i = 0; i < 3; i++) begin
      host.xfer(1'h0, ad[i], 32'h0, r, e);
      chk("read", r, rd_exp(i));
    end
  endtask
  task automatic rw(int i, logic [31:0] d);
    host.xfer(1'h1, ad[i], d, r, e);
    if (i == 0) sio = 32'h0000_0040 | d & 32'h0000_0007;
    else if (i == 1) ock = d & 32'h0000_001f;
    else inb = d & 32'hc0c7_ffff;
    host.xfer(1'h0, ad[i], 32'h0, r, e);
    chk("reg", r, rd_exp(i));
    chk("cfg", {cfg, src, cen, cf}, {inb[31:30], inb[23:22], inb[18:16], inb[15:0], ock[4:0]});
  endtask
  task automatic sclk_run(int half);
    repeat (48) begin
      repeat (half) @(posedge clk_in);
      sck <= ~sck;
    end
    #1;
  endtask
  always @(posedge clk_in) if (++cyc == 20000) begin
    err_count++;
    results();
  end
  initial begin
    ad = '{32'(gio_pkg::SERIAL_IO_ADDR), 32'(gio_pkg::OUT_CLOCK_ADDR), 32'(gio_pkg::IN_BAND_ADDR)};
    repeat (5) @(posedge clk_in);
    rst_in <= 1'h0;
    repeat (8) @(posedge clk_in);
    rdall();
    for (int k = 0; k < 15; k++) begin
      rnd = lfsr(rnd);
      {xtal, rec} <= rnd[5:0];
      rw(k % 3, {rnd, lfsr(rnd)});
    end
    host.xfer(1'h1, 32'h0000_0408, 32'hffff_ffff, r, e);
    chk("unmapped", e, 1'h1);
    host.xfer(1'h1, 32'h0000_0401, 32'hffff_ffff, r, e);
    chk("unaligned", e, 1'h1);
    rdall();
    for (int m = 0; m < 4; m++) begin
      rw(0, m & 2 ? 32'h4 : 32'h0);
      mv <= 1'h1;
      mp <= m[0];
      hv <= m[0];
      @(posedge clk_in);
      #1;
      chk("mgmt", ma, m[0] | m[1]);
      chk("host", ha, m[0]);
    end
    for (int k = 0; k < 4; k++) begin
      rw(0, 3 - k);
      sclk_run(k[0] ? 1 : 8);
      chk("edge", ri, k == 1 || k == 2);
    end
    iv <= 1'h1;
    for (int k = 0; k < 5; k++) begin
      rw(2, tab[k]);
      dst <= k == 1 ? ~mac : mac;
      @(posedge clk_in);
      #1;
      chk("accept", ia, inb[31] && inb[18:16] != 3'h7 && (!inb[30] || dst == mac));
    end
    rdall();
    results();
  end
endmodule
